// ---- include/bpl_cfg.svh ----
// Constants for the boot and clock-synthesiser configuration loader.
// Assumes a 10 MHz system clock; included by the RTL and the testbench.
//
// Operation
// - Low straps select post_divider and multiplier; input_div is fixed
// - Tile clock follows synthesiser ratio formula
// - Run-time write replaces all synthesiser values
// - Pins undriven while reset is low
// - Reset sequence, then pulls enabled, boot starts
// - High straps select boot source
// - Secure-boot bit forces boot from OTP
// - Image is length, program words, check word
// - Bypass check word skips CRC verification
// - Length and check word arrive LSB first
// - Program stored at RAM base, run there
// - CRC covers length and program bytes
// - Reflected CRC-32, preset ones, residue inverted
// - SPI master mode 0, read at zero
// - Link boot: ack word, image, end tokens
`ifndef BPL_CFG_SVH
`define BPL_CFG_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BPL_CLK_KHZ      10000
`define BPL_STRAP_EDGE   3
`define BPL_INIT_MIN_US  15
`define BPL_INIT_MAX_US  150
`define BPL_INIT_CYC     ((`BPL_INIT_MIN_US * `BPL_CLK_KHZ + 999) / 1000)
`define BPL_INIT_MAX_CYC ((`BPL_INIT_MAX_US * `BPL_CLK_KHZ) / 1000)
`define BPL_SPI_KHZ      2500
`define BPL_SPI_HALF_CYC (`BPL_CLK_KHZ / (2 * `BPL_SPI_KHZ))

// ----------------------------------------------------------------------------
// Strap and security fields
// ----------------------------------------------------------------------------
`define BPL_MODE_PLL_LSB 0
`define BPL_MODE_SRC_LSB 2
`define BPL_SEC_BOOT_BIT 5

// ----------------------------------------------------------------------------
// Synthesiser strap table
// ----------------------------------------------------------------------------
`define BPL_PLL00_POST   3'h1
`define BPL_PLL00_MULT   12'h07a
`define BPL_PLL11_POST   3'h2
`define BPL_PLL11_MULT   12'h077
`define BPL_PLL10_POST   3'h2
`define BPL_PLL10_MULT   12'h031
`define BPL_PLL01_POST   3'h2
`define BPL_PLL01_MULT   12'h017
`define BPL_PLL_INDIV    6'h00

// ----------------------------------------------------------------------------
// Image and link constants
// ----------------------------------------------------------------------------
`define BPL_CRC_POLY     32'hedb88320
`define BPL_CRC_INIT     32'hffffffff
`define BPL_CRC_BYPASS   32'h0d15ab1e
`define BPL_NULL_CHAN    32'h0000ff02
`define BPL_SPI_CMD      8'h03
`define BPL_SPI_ADDR     24'h000000

`endif

// ---- include/bpl_pkg.sv ----
// Types shared by the loader RTL.
// Assumes bpl_cfg.svh sits on the include path.
package bpl_pkg;

  typedef enum logic [2:0] {
    src_test, src_reserved, src_link, src_spi, src_otp
  } bpl_src_t;

  typedef enum logic [3:0] {
    st_strap, st_init, st_ack, st_len, st_prog, st_crc, st_endtok,
    st_check, st_run, st_idle, st_fail
  } bpl_state_t;

endpackage

// ---- rtl/bpl_crc_byte.sv ----
// One byte step of the reflected CRC-32, purely combinational.
// Assumes the byte is presented least significant bit first.
`timescale 1ns/1ps
`include "bpl_cfg.svh"

module bpl_crc_byte (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  byte_in,
  output logic      [31:0] crc_out
);

  logic [31:0] stage [0:8];

  assign stage[0] = crc_in;

  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign stage[i+1] = (stage[i] >> 1) ^
                        ((stage[i][0] ^ byte_in[i]) ? `BPL_CRC_POLY : 32'h0000_0000);
  end

  assign crc_out = stage[8];

endmodule

// ---- rtl/bpl_loader.sv ----
// Reset-time strap decode, synthesiser setup and boot image loader.
// Assumes synchronous straps and byte sources; RAM is written one word per cycle.
`timescale 1ns/1ps
`include "bpl_cfg.svh"

module bpl_loader
  import bpl_pkg::*;
#(
  parameter int RAM_AW = 14
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [3:0]        mode,
  input  wire logic [31:0]       security,
  input  wire logic              pll_wr,
  input  wire logic [2:0]        pll_wr_post_divider,
  input  wire logic [11:0]       pll_wr_loop_multiplier,
  input  wire logic [5:0]        pll_wr_input_div,
  input  wire logic [16:0]       osc_khz,
  output logic      [2:0]        post_divider,
  output logic      [11:0]       loop_multiplier,
  output logic      [5:0]        input_div,
  output logic      [31:0]       tile_khz,
  output logic                   pull_en,
  output bpl_src_t               boot_src,
  output logic                   spi_sclk,
  output logic                   spi_cs_n,
  output logic                   spi_mosi,
  output logic                   spi_oe,
  input  wire logic              spi_miso,
  input  wire logic              link_valid,
  input  wire logic [7:0]        link_data,
  input  wire logic              link_end,
  output logic                   link_ready,
  output logic                   link_end_out,
  output logic      [31:0]       link_ack_chan,
  input  wire logic              otp_valid,
  input  wire logic [7:0]        otp_data,
  output logic                   otp_ready,
  output logic                   ram_we,
  output logic      [RAM_AW-1:0] ram_addr,
  output logic      [31:0]       ram_wdata,
  output logic                   run,
  output logic      [RAM_AW-1:0] run_addr,
  output logic                   boot_fail
);

  if (RAM_AW < 2 || RAM_AW > 30) begin : g_chk
    $error("bpl_loader: RAM_AW out of range");
  end

  localparam logic [31:0] RAM_WORDS = 32'(1) << RAM_AW;

  // --------------------------------------------------------------------------
  // Synthesiser settings
  // --------------------------------------------------------------------------
  bpl_state_t  state;
  logic [10:0] cnt;
  logic        strap_take;
  logic [2:0]  next_post_divider;
  logic [11:0] next_loop_multiplier;
  logic [5:0]  next_input_div;
  logic [31:0] next_tile_khz;

  assign strap_take = (state == st_strap) && (cnt == 11'(`BPL_STRAP_EDGE - 1));

  always_comb begin
    next_post_divider    = post_divider;
    next_loop_multiplier = loop_multiplier;
    next_input_div       = input_div;
    if (pll_wr) begin
      next_post_divider    = pll_wr_post_divider;
      next_loop_multiplier = pll_wr_loop_multiplier;
      next_input_div       = pll_wr_input_div;
    end else if (strap_take) begin
      next_input_div = `BPL_PLL_INDIV;
      unique case (mode[`BPL_MODE_PLL_LSB +: 2])
        2'b00: begin next_post_divider = `BPL_PLL00_POST; next_loop_multiplier = `BPL_PLL00_MULT; end
        2'b11: begin next_post_divider = `BPL_PLL11_POST; next_loop_multiplier = `BPL_PLL11_MULT; end
        2'b10: begin next_post_divider = `BPL_PLL10_POST; next_loop_multiplier = `BPL_PLL10_MULT; end
        2'b01: begin next_post_divider = `BPL_PLL01_POST; next_loop_multiplier = `BPL_PLL01_MULT; end
      endcase
    end
    // Both register terms of the divisor are offset by one, so the divide never sees a zero term
    next_tile_khz = (32'(osc_khz) * (32'(loop_multiplier) + 32'h1)) /
                    (32'h2 * (32'(input_div) + 32'h1) * (32'(post_divider) + 32'h1));
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      post_divider    <= `BPL_PLL00_POST;
      loop_multiplier <= `BPL_PLL00_MULT;
      input_div       <= `BPL_PLL_INDIV;
      tile_khz        <= 32'h0000_0000;
    end else begin
      post_divider    <= next_post_divider;
      loop_multiplier <= next_loop_multiplier;
      input_div       <= next_input_div;
      tile_khz        <= next_tile_khz;
    end
  end

  // --------------------------------------------------------------------------
  // SPI flash reader
  // --------------------------------------------------------------------------
  logic        spi_run, spi_drv, spi_byte_v, rise, fall;
  logic [7:0]  spi_byte, rx_sh;
  logic [2:0]  rx_cnt;
  logic [5:0]  cmd_cnt;
  logic [31:0] tx_sh;
  logic [1:0]  spi_div;
  logic        next_sclk, next_cs_n, next_byte_v;
  logic [7:0]  next_byte, next_rx_sh;
  logic [2:0]  next_rx_cnt;
  logic [5:0]  next_cmd_cnt;
  logic [31:0] next_tx_sh;
  logic [1:0]  next_div;

  assign spi_run  = (boot_src == src_spi) &&
                    (state == st_len || state == st_prog || state == st_crc);
  assign spi_mosi = tx_sh[31];
  assign spi_oe   = nrst & spi_drv;
  assign rise     = !spi_cs_n && (spi_div == 2'(`BPL_SPI_HALF_CYC - 1)) && !spi_sclk;
  assign fall     = !spi_cs_n && (spi_div == 2'(`BPL_SPI_HALF_CYC - 1)) && spi_sclk;

  always_comb begin
    next_sclk    = 1'b0;
    next_cs_n    = 1'b1;
    next_div     = 2'h0;
    next_tx_sh   = {`BPL_SPI_CMD, `BPL_SPI_ADDR};
    next_cmd_cnt = 6'h00;
    next_rx_sh   = rx_sh;
    next_rx_cnt  = 3'h0;
    next_byte_v  = 1'b0;
    next_byte    = spi_byte;
    if (spi_run) begin
      next_cs_n    = 1'b0;
      next_sclk    = spi_sclk;
      next_tx_sh   = tx_sh;
      next_cmd_cnt = cmd_cnt;
      next_rx_cnt  = rx_cnt;
      next_div     = (spi_div == 2'(`BPL_SPI_HALF_CYC - 1)) ? 2'h0 : spi_div + 2'h1;
      if (rise) begin                                                   // Mode 0 samples here
        next_sclk = 1'b1;
        if (cmd_cnt != 6'd32) begin
          next_cmd_cnt = cmd_cnt + 6'h01;
        end else begin
          next_rx_sh  = {spi_miso, rx_sh[7:1]};
          next_rx_cnt = rx_cnt + 3'h1;
          if (rx_cnt == 3'h7) begin
            next_byte_v = 1'b1;
            next_byte   = {spi_miso, rx_sh[7:1]};
          end
        end
      end else if (fall) begin
        next_sclk  = 1'b0;
        next_tx_sh = {tx_sh[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      spi_sclk   <= 1'b0;
      spi_cs_n   <= 1'b1;
      spi_div    <= 2'h0;
      tx_sh      <= 32'h0000_0000;
      cmd_cnt    <= 6'h00;
      rx_sh      <= 8'h00;
      rx_cnt     <= 3'h0;
      spi_byte_v <= 1'b0;
      spi_byte   <= 8'h00;
    end else begin
      spi_sclk   <= next_sclk;
      spi_cs_n   <= next_cs_n;
      spi_div    <= next_div;
      tx_sh      <= next_tx_sh;
      cmd_cnt    <= next_cmd_cnt;
      rx_sh      <= next_rx_sh;
      rx_cnt     <= next_rx_cnt;
      spi_byte_v <= next_byte_v;
      spi_byte   <= next_byte;
    end
  end

  // --------------------------------------------------------------------------
  // Boot sequencer and image parser
  // --------------------------------------------------------------------------
  logic          byte_v, taking, word_done, crc_ok;
  logic [7:0]    byte_d;
  logic [31:0]   wsh, word, len, chk, crc, crc_step;
  logic [1:0]    bcnt;
  logic [RAM_AW:0] word_cnt;
  bpl_state_t    next_state;
  bpl_src_t      next_src;
  logic [10:0]   next_cnt;
  logic [1:0]    next_bcnt;
  logic [31:0]   next_wsh, next_len, next_chk, next_crc, next_ack;
  logic [RAM_AW:0] next_word_cnt;
  logic          next_pull, next_we, next_run, next_fail, next_end_out, next_drv;
  logic [RAM_AW-1:0] next_addr;
  logic [31:0]   next_wdata;

  assign taking     = (state == st_ack) || (state == st_len) ||
                      (state == st_prog) || (state == st_crc);
  assign link_ready = nrst && (boot_src == src_link) && (taking || state == st_endtok);
  assign otp_ready  = nrst && (boot_src == src_otp) && taking;
  assign run_addr   = '0;
  assign crc_ok     = (chk == `BPL_CRC_BYPASS) || (chk == ~crc);

  always_comb begin
    unique case (boot_src)
      src_spi:  begin byte_v = spi_byte_v;             byte_d = spi_byte;  end
      src_link: begin byte_v = link_valid && taking;   byte_d = link_data; end
      src_otp:  begin byte_v = otp_valid && taking;    byte_d = otp_data;  end
      default:  begin byte_v = 1'b0;                   byte_d = 8'h00;     end
    endcase
  end

  assign word      = {byte_d, wsh[31:8]};
  assign word_done = byte_v && (bcnt == 2'h3);

  bpl_crc_byte u_crc (
    .crc_in  (crc),
    .byte_in (byte_d),
    .crc_out (crc_step)
  );

  always_comb begin
    next_state    = state;
    next_src      = boot_src;
    next_cnt      = cnt;
    next_bcnt     = byte_v ? bcnt + 2'h1 : bcnt;
    next_wsh      = byte_v ? word : wsh;
    next_len      = len;
    next_chk      = chk;
    next_ack      = link_ack_chan;
    next_crc      = crc;
    next_word_cnt = word_cnt;
    next_pull     = pull_en;
    next_drv      = spi_drv;
    next_we       = 1'b0;
    next_addr     = ram_addr;
    next_wdata    = ram_wdata;
    next_run      = 1'b0;
    next_end_out  = 1'b0;
    next_fail     = boot_fail;
    unique case (state)
      st_strap: begin
        next_cnt = cnt + 11'h001;
        if (strap_take) begin
          next_cnt = 11'h000;
          next_state = st_init;
          if (security[`BPL_SEC_BOOT_BIT]) next_src = src_otp;
          else next_src = bpl_src_t'({1'b0, mode[`BPL_MODE_SRC_LSB +: 2]});
        end
      end
      st_init: begin
        next_cnt = cnt + 11'h001;
        if (cnt == 11'(`BPL_INIT_CYC - 1)) begin
          next_pull = 1'b1;
          unique case (boot_src)
            src_link: next_state = st_ack;
            src_spi:  begin next_state = st_len; next_drv = 1'b1; end
            src_otp:  next_state = st_len;
            default:  next_state = st_idle;
          endcase
        end
      end
      st_ack: if (word_done) begin
        next_ack   = word;
        next_state = st_len;
      end
      st_len: if (byte_v) begin
        next_crc = crc_step;
        if (word_done) begin
          next_len      = word;
          next_word_cnt = '0;
          if (word == 32'h0) next_state = st_crc;
          else if (word > RAM_WORDS) next_state = st_fail;
          else next_state = st_prog;
        end
      end
      st_prog: if (byte_v) begin
        next_crc = crc_step;
        if (word_done) begin
          next_we       = 1'b1;
          next_addr     = word_cnt[RAM_AW-1:0];
          next_wdata    = word;
          next_word_cnt = word_cnt + (RAM_AW+1)'(1);
          if (32'(word_cnt) + 32'h1 == len) next_state = st_crc;
        end
      end
      st_crc: if (word_done) begin
        next_chk   = word;
        next_state = (boot_src == src_link) ? st_endtok : st_check;
      end
      st_endtok: if (link_end) next_state = st_check;
      st_check: begin
        if (crc_ok) begin
          next_run     = 1'b1;
          next_state   = st_run;
          next_end_out = (boot_src == src_link) && (link_ack_chan != `BPL_NULL_CHAN);
        end else begin
          next_fail  = 1'b1;
          next_state = st_fail;
        end
      end
      st_fail:  next_fail = 1'b1;
      st_run, st_idle: ;
    endcase
    if (state == st_len && word_done && word > RAM_WORDS) next_fail = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state         <= st_strap;
      boot_src      <= src_test;
      cnt           <= 11'h000;
      bcnt          <= 2'h0;
      wsh           <= 32'h0000_0000;
      len           <= 32'h0000_0000;
      chk           <= 32'h0000_0000;
      link_ack_chan <= 32'h0000_0000;
      crc           <= `BPL_CRC_INIT;
      word_cnt      <= '0;
      pull_en       <= 1'b0;
      spi_drv       <= 1'b0;
      ram_we        <= 1'b0;
      ram_addr      <= '0;
      ram_wdata     <= 32'h0000_0000;
      run           <= 1'b0;
      link_end_out  <= 1'b0;
      boot_fail     <= 1'b0;
    end else begin
      state         <= next_state;
      boot_src      <= next_src;
      cnt           <= next_cnt;
      bcnt          <= next_bcnt;
      wsh           <= next_wsh;
      len           <= next_len;
      chk           <= next_chk;
      link_ack_chan <= next_ack;
      crc           <= next_crc;
      word_cnt      <= next_word_cnt;
      pull_en       <= next_pull;
      spi_drv       <= next_drv;
      ram_we        <= next_we;
      ram_addr      <= next_addr;
      ram_wdata     <= next_wdata;
      run           <= next_run;
      link_end_out  <= next_end_out;
      boot_fail     <= next_fail;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [10:0] rel_cnt;

  always_ff @(posedge clock) begin
    if (!nrst) rel_cnt <= 11'h000;
    else if (rel_cnt != 11'h7ff) rel_cnt <= rel_cnt + 11'h001;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  a_pll_strap_map: assert property ((strap_take && !pll_wr && mode[1:0] == 2'b11) |=>
    post_divider == 3'h2 && loop_multiplier == 12'h077 && input_div == 6'h00)
    else $error("strap 11 did not load synthesiser settings");
  a_pll_write_load: assert property (pll_wr |=> loop_multiplier == $past(pll_wr_loop_multiplier)
    && post_divider == $past(pll_wr_post_divider) && input_div == $past(pll_wr_input_div))
    else $error("synthesiser write not applied");
  a_pins_in_reset: assert property (@(posedge clock) disable iff (1'b0)
    !nrst |-> !spi_oe && !link_ready && !otp_ready)
    else $error("pin driven during reset");
  a_pull_delay_window: assert property ($rose(pull_en) |->
    rel_cnt >= 11'd152 && rel_cnt <= 11'd1500)
    else $error("pull enable outside reset window");
  a_secure_forces_otp: assert property ((strap_take && security[5]) |=> boot_src == src_otp)
    else $error("secure boot did not select OTP");
  a_src_spi_decode: assert property ((strap_take && !security[5] && mode[3:2] == 2'b11) |=>
    boot_src == src_spi)
    else $error("strap 11 did not select SPI");
  a_reserved_idle: assert property ((state == st_init && boot_src == src_reserved &&
    cnt == 11'd149) |=> state == st_idle ##1 state == st_idle)
    else $error("reserved source did not idle");
  a_bypass_accept: assert property ((state == st_check && chk == 32'h0d15ab1e) |=>
    run && !boot_fail && state == st_run)
    else $error("bypass word not accepted");
  a_crc_mismatch: assert property ((state == st_check && chk != 32'h0d15ab1e && chk != ~crc)
    |=> boot_fail && !run ##1 !run)
    else $error("bad CRC did not fail");
  a_end_reply: assert property ((state == st_check && crc_ok && boot_src == src_link &&
    link_ack_chan != 32'h0000ff02) |=> link_end_out ##1 !link_end_out)
    else $error("end token reply missing");
  a_spi_half_period: assert property ($changed(spi_sclk) && !spi_cs_n |=> $stable(spi_sclk))
    else $error("SPI clock half period too short");

endmodule

// ---- verification/bpl_flash.sv ----
// Behavioural SPI boot flash holding a one-word image with the bypass check word.
// Assumes mode 0 clocking, one read per select, data after 32 command clocks.
`timescale 1ns/1ps

module bpl_flash (
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  output logic      spi_miso
);
  logic [7:0] mem [0:11];
  int         nclk = 0;
  int         bitn;

  initial begin
    mem = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11,
            8'h1e, 8'hab, 8'h15, 8'h0d};
    spi_miso = 1'b0;
  end

  always @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) nclk <= 0;
    else nclk <= nclk + 1;
  end

  // Outside the data phase the line toggles, so a stale value is never mistaken for data
  always @(negedge spi_sclk or posedge spi_cs_n) begin
    bitn = nclk - 32;
    if (spi_cs_n || bitn < 0 || bitn > 95) spi_miso <= ~spi_miso;
    else spi_miso <= mem[bitn / 8][bitn % 8];
  end
endmodule

// ---- verification/test_bpl_loader.sv ----
// Self-checking bench for the loader: straps, synthesiser, OTP, link and SPI boot.
// Assumes the flash model in bpl_flash.sv and a 10 MHz clock.
`timescale 1ns/1ps
`include "bpl_cfg.svh"
`define CK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end

module test_bpl_loader
  import bpl_pkg::*;
;
  logic        clock = 0, nrst = 0, pll_wr = 0, link_valid = 0, link_end = 0, otp_valid = 0;
  logic [3:0]  mode = '0;
  logic [31:0] security = '0, link_ack_chan, tile_khz, ram_wdata, cmd_sh = '0;
  logic [2:0]  pll_wr_post_divider = '0, post_divider;
  logic [11:0] pll_wr_loop_multiplier = '0, loop_multiplier;
  logic [5:0]  pll_wr_input_div = '0, input_div;
  logic [7:0]  link_data = '0, otp_data = '0;
  logic [13:0] ram_addr, run_addr;
  logic        pull_en, spi_sclk, spi_cs_n, spi_mosi, spi_oe, spi_miso, link_ready;
  logic        link_end_out, otp_ready, ram_we, run, boot_fail;
  bpl_src_t    boot_src;
  logic [31:0] exp_w [0:3];
  int          err_total = 0, compares = 0, wi = 0, sk = 0, cyc = 0;

  bpl_loader dut_u (.clock(clock), .nrst(nrst), .mode(mode), .security(security),
    .pll_wr(pll_wr), .pll_wr_post_divider(pll_wr_post_divider),
    .pll_wr_loop_multiplier(pll_wr_loop_multiplier), .pll_wr_input_div(pll_wr_input_div),
    .osc_khz(17'd12000), .post_divider(post_divider), .loop_multiplier(loop_multiplier),
    .input_div(input_div), .tile_khz(tile_khz), .pull_en(pull_en), .boot_src(boot_src),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_oe(spi_oe),
    .spi_miso(spi_miso), .link_valid(link_valid), .link_data(link_data),
    .link_end(link_end), .link_ready(link_ready), .link_end_out(link_end_out),
    .link_ack_chan(link_ack_chan), .otp_valid(otp_valid), .otp_data(otp_data),
    .otp_ready(otp_ready), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .run(run), .run_addr(run_addr), .boot_fail(boot_fail));

  // Select has a pull-up and the clock idles low while the pins are released
  bpl_flash flash_u (.spi_sclk(spi_oe ? spi_sclk : 1'b0),
    .spi_cs_n(spi_oe ? spi_cs_n : 1'b1), .spi_miso(spi_miso));

  initial forever #50 clock = ~clock;

  // ----------------------------------------------------------------------------
  // Monitors and helpers
  // ----------------------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
    if (ram_we === 1'b1 && wi < 4) begin
      `CK(ram_addr, wi[13:0])
      `CK(ram_wdata, exp_w[wi])
      wi++;
    end
  end

  always @(posedge spi_sclk) if (spi_cs_n === 1'b0 && sk < 32) begin
    cmd_sh <= {cmd_sh[30:0], spi_mosi};
    sk++;
  end

  function automatic logic [31:0] cb(input logic [31:0] c, input logic [31:0] w);
    for (int i = 0; i < 32; i++) c = (c >> 1) ^ ((c[0] ^ w[i]) ? `BPL_CRC_POLY : 32'h0);
    return c;
  endfunction

  task automatic rst(input logic [3:0] m, input logic [31:0] s);
    @(posedge clock);
    nrst <= 1'b0;
    mode <= m;
    security <= s;
    repeat (8) @(posedge clock);
    `CK(spi_oe | link_ready | otp_ready, 1'b0)
    nrst <= 1'b1;
    wi = 0;
    sk = 0;
    @(posedge clock);
  endtask

  task automatic wpull;
    int n;
    n = 1;
    while (pull_en !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    `CK(n >= 151 && n <= 1501, 1'b1)
    @(posedge clock);
  endtask

  task automatic sb(input bit o, input logic [7:0] b);
    if (o) begin
      otp_valid <= 1'b1;
      otp_data <= b;
    end else begin
      link_valid <= 1'b1;
      link_data <= b;
    end
    for (int k = 0; k < 400; k++) begin
      @(negedge clock);
      if ((o ? otp_ready : link_ready) === 1'b1) break;
    end
    @(posedge clock);
  endtask

  // Least significant byte goes out first
  task automatic sw(input bit o, input logic [31:0] w);
    for (int i = 0; i < 4; i++) sb(o, w[8*i +: 8]);
  endtask

  // Check kind: 0 correct, 1 bypass word, 2 residue left uninverted
  task automatic img(input bit o, input int n, input int kind);
    logic [31:0] c;
    c = cb(`BPL_CRC_INIT, n);
    sw(o, n);
    for (int i = 0; i < n; i++) begin
      exp_w[i] = 32'hc0de0000 + 32'h01010101 * i;
      c = cb(c, exp_w[i]);
      sw(o, exp_w[i]);
    end
    sw(o, kind == 0 ? ~c : kind == 1 ? `BPL_CRC_BYPASS : c);
    otp_valid <= 1'b0;
    link_valid <= 1'b0;
  endtask

  task automatic fin(input logic ok, input logic eo, input int n);
    int k;
    k = 0;
    while (run !== 1'b1 && boot_fail !== 1'b1 && k < 2000) begin
      @(negedge clock);
      k++;
    end
    `CK(run, ok)
    `CK(boot_fail, ~ok)
    `CK(link_end_out, eo)
    `CK(run_addr, 14'h0)
    `CK(wi, n)
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_strap;
    logic [3:0]  m [4] = '{4'b0000, 4'b0111, 4'b0010, 4'b0101};
    logic [2:0]  od [4] = '{3'h1, 3'h2, 3'h2, 3'h2};
    logic [11:0] f [4] = '{12'd122, 12'd119, 12'd49, 12'd23};
    for (int i = 0; i < 4; i++) begin
      rst(m[i], 32'h0);
      wpull();
      `CK({post_divider, loop_multiplier, input_div}, {od[i], f[i], 6'h0})
      `CK(tile_khz, 12000 * (f[i] + 1) / (2 * (od[i] + 1)))
      `CK(boot_src, m[i][2] ? src_reserved : src_test)
      repeat (50) @(negedge clock);
      `CK(run | spi_oe | link_ready | otp_ready, 1'b0)
    end
  endtask

  task automatic t_pll;
    @(posedge clock);
    pll_wr <= 1'b1;
    pll_wr_post_divider <= 3'h3;
    pll_wr_loop_multiplier <= 12'hfff;
    pll_wr_input_div <= 6'h3f;
    @(posedge clock);
    pll_wr <= 1'b0;
    @(negedge clock);
    `CK({post_divider, loop_multiplier, input_div}, {3'h3, 12'hfff, 6'h3f})
    @(negedge clock);
    `CK(tile_khz, 12000 * 4096 / (2 * 64 * 4))
  endtask

  // Secure boot over SPI straps must still come from OTP
  task automatic t_otp(input int kind);
    rst(4'b1111, 32'h20);
    wpull();
    `CK(boot_src, src_otp)
    img(1, 3, kind);
    fin(kind != 2, 1'b0, 3);
  endtask

  // The null channel word suppresses the end token reply
  task automatic t_link(input logic [31:0] ack);
    rst(4'b1000, 32'h0);
    wpull();
    `CK(boot_src, src_link)
    sw(0, ack);
    img(0, 2, 0);
    link_end <= 1'b1;
    for (int k = 0; k < 400; k++) begin
      @(negedge clock);
      if (link_ready === 1'b1) break;
    end
    @(posedge clock);
    link_end <= 1'b0;
    `CK(link_ack_chan, ack)
    fin(1'b1, ack != `BPL_NULL_CHAN, 2);
  endtask

  task automatic t_spi;
    rst(4'b1100, 32'h0);
    wpull();
    `CK(boot_src, src_spi)
    exp_w[0] = 32'h11223344;
    fin(1'b1, 1'b0, 1);
    `CK(cmd_sh, {`BPL_SPI_CMD, `BPL_SPI_ADDR})
  endtask

  task automatic test_done;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    t_strap();
    t_pll();
    for (int kind = 0; kind < 3; kind++) t_otp(kind);
    t_link(32'h00001234);
    t_link(`BPL_NULL_CHAN);
    t_spi();
    test_done();
  end
endmodule
